// ==== tpps_pkg.sv ====
// Package with register map, field layout, reset values and routing codes for the pin set-up block.
package tpps_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the register bus.
    localparam logic [4:0] OFS_PORT_LATCH  = 5'h00;
    localparam logic [4:0] OFS_PORT_DIR    = 5'h04;
    localparam logic [4:0] OFS_STANDBY     = 5'h08;
    localparam logic [4:0] OFS_CLK_PIN_SEL = 5'h0c;
    localparam logic [4:0] OFS_AB_PIN_SEL  = 5'h10;
    localparam logic [4:0] OFS_CD_PIN_SEL  = 5'h14;
    localparam logic [4:0] OFS_IRQ_CTRL    = 5'h18;
    localparam logic [4:0] OFS_TRIG_CTRL   = 5'h1c;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int STANDBY_BIT  = 5;
    localparam int CLK_SEL_LSB  = 4;
    localparam int A_SEL_LSB    = 0;
    localparam int B_SEL_LSB    = 4;
    localparam int C_SEL_LSB    = 0;
    localparam int D_SEL_LSB    = 4;
    localparam int IRQ_LVL_LSB  = 0;
    localparam int IRQ_FLAG_BIT = 3;
    localparam int PIN_B_IDX    = 2;
    localparam int PIN_C_IDX    = 3;
    localparam int PIN_D_IDX    = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] RST_PORT_LATCH = 8'h00;
    localparam logic [7:0] RST_PORT_DIR   = 8'h00;
    localparam logic [7:0] RST_STANDBY    = 8'h20;
    localparam logic [2:0] RST_SEL        = 3'h0;
    localparam logic [2:0] RST_IRQ_LVL    = 3'h0;
    localparam logic [3:0] RST_TRIG_EN    = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Routing codes: which selector value puts which function on which port pin.
    localparam logic [2:0] SEL_NONE   = 3'h0;
    localparam logic [2:0] SEL_CLK_P0 = 3'h1;
    localparam logic [2:0] SEL_A_P1   = 3'h1;
    localparam logic [2:0] SEL_B_P2   = 3'h7;
    localparam logic [2:0] SEL_C_P3   = 3'h6;
    localparam logic [2:0] SEL_D_P4   = 3'h6;
    localparam logic [2:0] PIN_CLK    = 3'h0;
    localparam logic [2:0] PIN_A      = 3'h1;

    typedef enum logic [2:0] {
        FN_CLK = 3'h0,
        FN_A   = 3'h1,
        FN_B   = 3'h2,
        FN_C   = 3'h3,
        FN_D   = 3'h4
    } tpps_fn_e;

    // Returns {valid, pin index} for a function and its selector value.
    function automatic logic [3:0] tpps_route(input tpps_fn_e fn, input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h0;
        case (fn)
            FN_CLK:  r = (sel == SEL_CLK_P0) ? {1'b1, PIN_CLK} : 4'h0;
            FN_A:    r = (sel == SEL_A_P1) ? {1'b1, PIN_A} : 4'h0;
            FN_B:    r = (sel == SEL_B_P2) ? {1'b1, 3'(PIN_B_IDX)} : 4'h0;
            FN_C:    r = (sel == SEL_C_P3) ? {1'b1, 3'(PIN_C_IDX)} : 4'h0;
            FN_D:    r = (sel == SEL_D_P4) ? {1'b1, 3'(PIN_D_IDX)} : 4'h0;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

endpackage

// ==== tpps_route.sv ====
// Pin router that places timer channels and inputs onto port pins by selector value.
`timescale 1ns/1ps
module tpps_route
    import tpps_pkg::*;
(
    // Selector fields.
    input  wire logic [2:0] clk_sel,
    input  wire logic [2:0] a_sel,
    input  wire logic [2:0] b_sel,
    input  wire logic [2:0] c_sel,
    input  wire logic [2:0] d_sel,
    // Timer channel outputs.
    input  wire logic       chan_b_out,
    input  wire logic       chan_c_out,
    input  wire logic       chan_d_out,
    // Synchronised pin levels.
    input  wire logic [7:0] pins_sync,
    // Routed results.
    output logic      [7:0] func_drive,
    output logic      [7:0] func_val,
    output logic            ext_clk_in,
    output logic            chan_a_in
);

    logic [3:0] rt_clk;
    logic [3:0] rt_a;
    logic [3:0] rt_b;
    logic [3:0] rt_c;
    logic [3:0] rt_d;

    assign rt_clk = tpps_route(FN_CLK, clk_sel);
    assign rt_a   = tpps_route(FN_A, a_sel);
    assign rt_b   = tpps_route(FN_B, b_sel);
    assign rt_c   = tpps_route(FN_C, c_sel);
    assign rt_d   = tpps_route(FN_D, d_sel);

    // A disconnected input reads low to the timer.
    assign ext_clk_in = rt_clk[3] & pins_sync[rt_clk[2:0]];
    assign chan_a_in  = rt_a[3] & pins_sync[rt_a[2:0]];

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            always_comb begin
                func_drive[i] = 1'b0;
                func_val[i]   = 1'b0;
                if (rt_b[3] && rt_b[2:0] == 3'(i)) begin
                    func_drive[i] = 1'b1;
                    func_val[i]   = chan_b_out;
                end else if (rt_c[3] && rt_c[2:0] == 3'(i)) begin
                    func_drive[i] = 1'b1;
                    func_val[i]   = chan_c_out;
                end else if (rt_d[3] && rt_d[2:0] == 3'(i)) begin
                    func_drive[i] = 1'b1;
                    func_val[i]   = chan_d_out;
                end
            end
        end
    endgenerate

endmodule // tpps_route

// ==== tpps_top.sv ====
// Register file, pin drive and interrupt flag logic for the timer PWM pin set-up block.
`timescale 1ns/1ps
module tpps_top
    import tpps_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        srst,
    // Register bus slave.
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Port pins.
    input  wire logic [7:0]  port_pin_in,
    output logic      [7:0]  port_pin_out,
    output logic      [7:0]  port_pin_oe,
    // Timer unit side.
    input  wire logic        channel_b_pin,
    input  wire logic        channel_c_pin,
    input  wire logic        channel_d_pin,
    input  wire logic        timer_irq_event,
    input  wire logic        irq_ack,
    input  wire logic [3:0]  compare_match,
    output logic             timer_active,
    output logic             timer_ext_clock_input,
    output logic             timer_trigger_input,
    output logic             irq_request,
    output logic      [2:0]  irq_level,
    output logic             converter_trigger
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0]  latch_r;
    logic [7:0]  dir_r;
    logic        standby_r;
    logic [2:0]  clk_sel_r;
    logic [2:0]  a_sel_r;
    logic [2:0]  b_sel_r;
    logic [2:0]  c_sel_r;
    logic [2:0]  d_sel_r;
    logic [2:0]  irq_lvl_r;
    logic        irq_pending_flag_r;
    logic [3:0]  trig_en_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [7:0]  pin_meta_r;
    logic [7:0]  pin_sync_r;
    logic [7:0]  pin_out_r;
    logic [7:0]  pin_oe_r;
    logic        ext_clk_r;
    logic        trig_in_r;
    logic        conv_trig_r;
    logic        wr_go;
    logic        req;
    logic [7:0]  wbyte;
    logic [7:0]  func_drive;
    logic [7:0]  func_val;
    logic        ext_clk_in;
    logic        chan_a_in;
    logic [7:0]  rd_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: every access stalls one cycle, then completes.

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign wbyte           = avs_writedata[7:0];
    assign avs_readdata    = rdata_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        case (avs_address)
            OFS_PORT_LATCH:  rd_nxt = latch_r;
            OFS_PORT_DIR:    rd_nxt = dir_r;
            OFS_STANDBY:     rd_nxt = 8'(standby_r) << STANDBY_BIT;
            OFS_CLK_PIN_SEL: rd_nxt = 8'(clk_sel_r) << CLK_SEL_LSB;
            OFS_AB_PIN_SEL:  rd_nxt = (8'(b_sel_r) << B_SEL_LSB) | (8'(a_sel_r) << A_SEL_LSB);
            OFS_CD_PIN_SEL:  rd_nxt = (8'(d_sel_r) << D_SEL_LSB) | (8'(c_sel_r) << C_SEL_LSB);
            OFS_IRQ_CTRL:    rd_nxt = (8'(irq_pending_flag_r) << IRQ_FLAG_BIT)
                                      | (8'(irq_lvl_r) << IRQ_LVL_LSB);
            OFS_TRIG_CTRL:   rd_nxt = {4'h0, trig_en_r};
            default:         rd_nxt = 8'h00;
        endcase
    end

    // Read data are captured in the stall cycle and stand at the completing edge.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= {24'h00_0000, rd_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port latch and direction.

    always_ff @(posedge mclk) begin
        if (srst) begin
            latch_r <= RST_PORT_LATCH;
        end else if (wr_go && avs_address == OFS_PORT_LATCH) begin
            latch_r <= wbyte;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            dir_r <= RST_PORT_DIR;
        end else if (wr_go && avs_address == OFS_PORT_DIR) begin
            dir_r <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Standby, selectors, interrupt level and trigger enables.

    always_ff @(posedge mclk) begin
        if (srst) begin
            standby_r <= RST_STANDBY[STANDBY_BIT];
        end else if (wr_go && avs_address == OFS_STANDBY) begin
            standby_r <= wbyte[STANDBY_BIT];
        end
    end

    assign timer_active = ~standby_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_sel_r <= RST_SEL;
            a_sel_r   <= RST_SEL;
            b_sel_r   <= RST_SEL;
            c_sel_r   <= RST_SEL;
            d_sel_r   <= RST_SEL;
        end else if (wr_go) begin
            if (avs_address == OFS_CLK_PIN_SEL) begin
                clk_sel_r <= wbyte[CLK_SEL_LSB +: 3];
            end
            if (avs_address == OFS_AB_PIN_SEL) begin
                a_sel_r <= wbyte[A_SEL_LSB +: 3];
                b_sel_r <= wbyte[B_SEL_LSB +: 3];
            end
            if (avs_address == OFS_CD_PIN_SEL) begin
                c_sel_r <= wbyte[C_SEL_LSB +: 3];
                d_sel_r <= wbyte[D_SEL_LSB +: 3];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_lvl_r <= RST_IRQ_LVL;
        end else if (wr_go && avs_address == OFS_IRQ_CTRL) begin
            irq_lvl_r <= wbyte[IRQ_LVL_LSB +: 3];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            trig_en_r <= RST_TRIG_EN;
        end else if (wr_go && avs_address == OFS_TRIG_CTRL) begin
            trig_en_r <= wbyte[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt request flag: set by the timer, cleared by acknowledge; set wins.

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_pending_flag_r <= 1'b0;
        end else if (timer_irq_event && timer_active) begin
            irq_pending_flag_r <= 1'b1;
        end else if (irq_ack) begin
            irq_pending_flag_r <= 1'b0;
        end
    end

    assign irq_request = irq_pending_flag_r & (irq_lvl_r != 3'h0);
    assign irq_level   = irq_lvl_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Converter trigger, gated per compare register.

    always_ff @(posedge mclk) begin
        if (srst) begin
            conv_trig_r <= 1'b0;
        end else begin
            conv_trig_r <= timer_active & |(compare_match & trig_en_r);
        end
    end

    assign converter_trigger = conv_trig_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, routing and output drive.

    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= port_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    tpps_route u_route (
        .clk_sel    (clk_sel_r),
        .a_sel      (a_sel_r),
        .b_sel      (b_sel_r),
        .c_sel      (c_sel_r),
        .d_sel      (d_sel_r),
        .chan_b_out (channel_b_pin),
        .chan_c_out (channel_c_pin),
        .chan_d_out (channel_d_pin),
        .pins_sync  (pin_sync_r),
        .func_drive (func_drive),
        .func_val   (func_val),
        .ext_clk_in (ext_clk_in),
        .chan_a_in  (chan_a_in)
    );

    // A routed channel takes the pin only while the timer is active; else the latch drives.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_out_r <= 8'h00;
            pin_oe_r  <= 8'h00;
        end else begin
            pin_out_r <= (func_drive & {8{timer_active}} & func_val)
                         | (~(func_drive & {8{timer_active}}) & latch_r);
            pin_oe_r  <= dir_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_clk_r <= 1'b0;
            trig_in_r <= 1'b0;
        end else begin
            ext_clk_r <= ext_clk_in;
            trig_in_r <= chan_a_in;
        end
    end

    assign port_pin_out          = pin_out_r;
    assign port_pin_oe           = pin_oe_r;
    assign timer_ext_clock_input = ext_clk_r;
    assign timer_trigger_input   = trig_in_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    dir_to_oe_a : assert property (@(posedge mclk) disable iff (srst)
        (wr_go && avs_address == OFS_PORT_DIR) |-> ##2 (port_pin_oe == $past(wbyte, 2)))
        else $error("direction write did not reach output enables");

    standby_gate_a : assert property (@(posedge mclk) disable iff (srst)
        (wr_go && avs_address == OFS_STANDBY) |=> (timer_active == !$past(wbyte[STANDBY_BIT])))
        else $error("standby bit did not set timer activity");

    clk_none_a : assert property (@(posedge mclk) disable iff (srst)
        ($past(clk_sel_r) == SEL_NONE) |-> !timer_ext_clock_input)
        else $error("external clock input connected while unselected");

    trig_none_a : assert property (@(posedge mclk) disable iff (srst)
        ($past(a_sel_r) == SEL_NONE) |-> !timer_trigger_input)
        else $error("channel A input connected while unselected");

    chan_b_route_a : assert property (@(posedge mclk) disable iff (srst)
        (b_sel_r == SEL_B_P2 && timer_active) |=> (port_pin_out[PIN_B_IDX] == $past(channel_b_pin)))
        else $error("channel B not on pin 5.2");

    chan_c_route_a : assert property (@(posedge mclk) disable iff (srst)
        (c_sel_r == SEL_C_P3 && timer_active) |=> (port_pin_out[PIN_C_IDX] == $past(channel_c_pin)))
        else $error("channel C not on pin 5.3");

    chan_d_route_a : assert property (@(posedge mclk) disable iff (srst)
        (d_sel_r == SEL_D_P4 && timer_active) |=> (port_pin_out[PIN_D_IDX] == $past(channel_d_pin)))
        else $error("channel D not on pin 5.4");

    irq_level_off_a : assert property (@(posedge mclk) disable iff (srst)
        (irq_lvl_r == 3'h0) |-> !irq_request)
        else $error("interrupt raised at level zero");

    irq_flag_set_a : assert property (@(posedge mclk) disable iff (srst)
        (timer_irq_event && timer_active) |=> irq_pending_flag_r)
        else $error("pending flag missed an event");

    trig_mask_a : assert property (@(posedge mclk) disable iff (srst)
        ((compare_match & trig_en_r) == 4'h0) |=> !converter_trigger)
        else $error("converter trigger not suppressed");

    unmapped_zero_a : assert property (@(posedge mclk) disable iff (srst)
        (avs_read && !ack_r && avs_address[1:0] != 2'h0) |=> (avs_readdata == 32'h0))
        else $error("unmapped read not zero");

    irq_flag_clear_a : assert property (@(posedge mclk) disable iff (srst)
        (irq_ack && !(timer_irq_event && timer_active)) |=> !irq_pending_flag_r)
        else $error("pending flag not cleared by acknowledge");

    irq_flag_ro_a : assert property (@(posedge mclk) disable iff (srst)
        (wr_go && avs_address == OFS_IRQ_CTRL && !timer_irq_event && !irq_ack)
        |=> (irq_pending_flag_r == $past(irq_pending_flag_r)))
        else $error("pending flag changed by a register write");

    sel_write_a : assert property (@(posedge mclk) disable iff (srst)
        (wr_go && avs_address == OFS_AB_PIN_SEL)
        |=> (b_sel_r == $past(wbyte[6:4]) && a_sel_r == $past(wbyte[2:0])))
        else $error("selector write did not land at the next edge");

    trig_pass_a : assert property (@(posedge mclk) disable iff (srst)
        (timer_active && (compare_match & trig_en_r) != 4'h0) |=> converter_trigger)
        else $error("enabled converter trigger lost");

    cover_pin_b_c : cover property (@(posedge mclk) disable iff (srst)
        b_sel_r == SEL_B_P2 && pin_oe_r[PIN_B_IDX] && timer_active);
    cover_irq_c : cover property (@(posedge mclk) disable iff (srst)
        irq_request ##1 irq_ack);
    cover_trig_c : cover property (@(posedge mclk) disable iff (srst)
        converter_trigger);
    cover_route_cd_c : cover property (@(posedge mclk) disable iff (srst)
        c_sel_r == SEL_C_P3 && d_sel_r == SEL_D_P4 && timer_active);

endmodule // tpps_top

// ==== tpps_pin_model.sv ====
// Behavioural model of the board side of the port pins.
`timescale 1ns/1ps
module tpps_pin_model (
    // Clock.
    input  wire logic       mclk,
    // Device drive.
    input  wire logic [7:0] port_pin_out,
    input  wire logic [7:0] port_pin_oe,
    // Board drive.
    input  wire logic [7:0] ext_drive,
    input  wire logic [7:0] ext_level,
    // Resolved pin levels.
    output logic      [7:0] port_pin_in
);
    logic [7:0] float_r = 8'h55;

    // A pin that nobody drives wanders, so a stale level never passes as valid.
    always @(posedge mclk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_drive & ext_level)
                    | (~port_pin_oe & ~ext_drive & float_r);
    end
endmodule // tpps_pin_model

// ==== tpps_top_tb.sv ====
// Self-checking testbench for the timer pin set-up block.
`timescale 1ns/1ps
module tpps_top_tb
    import tpps_pkg::*;
;
    logic        mclk, srst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_data;
    logic [7:0]  port_pin_in, port_pin_out, port_pin_oe, ext_drive, ext_level;
    logic        channel_b_pin, channel_c_pin, channel_d_pin, timer_irq_event, irq_ack;
    logic [3:0]  compare_match;
    logic        timer_active, timer_ext_clock_input, timer_trigger_input;
    logic        irq_request, converter_trigger;
    logic [2:0]  irq_level;
    int          fail_count, tests_run;
    logic [4:0]  ofs_t [8] = '{OFS_PORT_LATCH, OFS_PORT_DIR, OFS_STANDBY, OFS_CLK_PIN_SEL,
                               OFS_AB_PIN_SEL, OFS_CD_PIN_SEL, OFS_IRQ_CTRL, OFS_TRIG_CTRL};
    logic [7:0]  rst_t [8] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    ////////////////////////////////////////////////////////////////////////////////
    tpps_top dut_u (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .channel_b_pin(channel_b_pin), .channel_c_pin(channel_c_pin),
        .channel_d_pin(channel_d_pin), .timer_irq_event(timer_irq_event), .irq_ack(irq_ack),
        .compare_match(compare_match), .timer_active(timer_active),
        .timer_ext_clock_input(timer_ext_clock_input),
        .timer_trigger_input(timer_trigger_input), .irq_request(irq_request),
        .irq_level(irq_level), .converter_trigger(converter_trigger));

    tpps_pin_model pm_u (.mclk(mclk), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .ext_drive(ext_drive), .ext_level(ext_level), .port_pin_in(port_pin_in));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until waitrequest is seen low, then idles one cycle.
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
        rd_data = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_xfer(1'b1, a, d);
    endtask

    task automatic rd(input string name, input logic [4:0] a, input logic [7:0] exp);
        bus_xfer(1'b0, a, 8'h00);
        chk(name, {24'h0, exp}, rd_data);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic finish_test;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        cyc(20000);
        chk("watchdog", 32'h0, 32'h1);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        {ext_drive, ext_level, compare_match} = '0;
        {channel_b_pin, channel_c_pin, channel_d_pin, timer_irq_event, irq_ack} = '0;
        fail_count = 0;
        tests_run = 0;
        cyc(4);
        srst <= 1'b0;
        cyc(1);
        for (int i = 0; i < 8; i++) rd("reset value", ofs_t[i], rst_t[i]);
        rd("unmapped", 5'h1d, 8'h00);
        wr(5'h1e, 8'hff);
        rd("latch after unmapped write", OFS_PORT_LATCH, 8'h00);
        chk("timer_active reset", 32'h0, {31'h0, timer_active});
        wr(OFS_PORT_LATCH, 8'h00);
        wr(OFS_PORT_DIR, 8'h1c);
        cyc(1);
        chk("port_pin_oe", 32'h1c, {24'h0, port_pin_oe});
        chk("port_pin_out", 32'h0, {24'h0, port_pin_out});
        wr(OFS_STANDBY, 8'h00);
        chk("timer_active", 32'h1, {31'h0, timer_active});
        rd("standby", OFS_STANDBY, 8'h00);
        channel_b_pin <= 1'b1;
        channel_c_pin <= 1'b1;
        channel_d_pin <= 1'b1;
        wr(OFS_AB_PIN_SEL, 8'hff);
        rd("ab select", OFS_AB_PIN_SEL, 8'h77);
        wr(OFS_CD_PIN_SEL, 8'h66);
        cyc(2);
        chk("routed bcd", 32'h7, {29'h0, port_pin_out[4:2]});
        channel_b_pin <= 1'b0;
        channel_d_pin <= 1'b0;
        cyc(3);
        chk("routed bcd level", 32'h2, {29'h0, port_pin_out[4:2]});
        channel_b_pin <= 1'b1;
        wr(OFS_CD_PIN_SEL, 8'h77);
        cyc(2);
        chk("cd unrouted", 32'h1, {29'h0, port_pin_out[4:2]});
        wr(OFS_STANDBY, 8'h20);
        cyc(2);
        chk("standby pins", 32'h0, {29'h0, port_pin_out[4:2]});
        chk("timer_active standby", 32'h0, {31'h0, timer_active});
        wr(OFS_STANDBY, 8'h00);
        ext_drive <= 8'h03;
        ext_level <= 8'h03;
        wr(OFS_AB_PIN_SEL, 8'h70);
        cyc(4);
        chk("ext clock unselected", 32'h0, {31'h0, timer_ext_clock_input});
        chk("trigger unselected", 32'h0, {31'h0, timer_trigger_input});
        wr(OFS_CLK_PIN_SEL, 8'h10);
        wr(OFS_AB_PIN_SEL, 8'h71);
        cyc(4);
        chk("ext clock selected", 32'h1, {31'h0, timer_ext_clock_input});
        chk("trigger selected", 32'h1, {31'h0, timer_trigger_input});
        wr(OFS_IRQ_CTRL, 8'h00);
        timer_irq_event <= 1'b1;
        cyc(1);
        timer_irq_event <= 1'b0;
        cyc(1);
        chk("irq level zero", 32'h0, {31'h0, irq_request});
        rd("irq pending", OFS_IRQ_CTRL, 8'h08);
        for (int l = 0; l < 8; l++) begin
            wr(OFS_IRQ_CTRL, 8'hf0 | 8'(l));
            chk("irq_level", 32'(l), {29'h0, irq_level});
            chk("irq_request", {31'h0, l != 0}, {31'h0, irq_request});
            rd("irq ctrl", OFS_IRQ_CTRL, 8'h08 | 8'(l));
        end
        irq_ack <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        cyc(1);
        chk("irq cleared", 32'h0, {31'h0, irq_request});
        rd("irq ctrl cleared", OFS_IRQ_CTRL, 8'h07);
        timer_irq_event <= 1'b1;
        irq_ack <= 1'b1;
        cyc(1);
        timer_irq_event <= 1'b0;
        irq_ack <= 1'b0;
        cyc(1);
        chk("irq set wins", 32'h1, {31'h0, irq_request});
        rd("irq ctrl set wins", OFS_IRQ_CTRL, 8'h0f);
        wr(OFS_TRIG_CTRL, 8'hf5);
        rd("trigger enables", OFS_TRIG_CTRL, 8'h05);
        for (int i = 0; i < 4; i++) begin
            compare_match <= 4'(1 << i);
            cyc(1);
            compare_match <= 4'h0;
            cyc(1);
            chk("converter_trigger", {31'h0, i[0] == 1'b0}, {31'h0, converter_trigger});
            cyc(1);
            chk("converter_trigger end", 32'h0, {31'h0, converter_trigger});
        end
        srst <= 1'b1;
        cyc(1);
        srst <= 1'b0;
        cyc(1);
        rd("standby after reset", OFS_STANDBY, 8'h20);
        chk("oe after reset", 32'h0, {24'h0, port_pin_oe});
        finish_test();
    end
endmodule // tpps_top_tb
